// file: logic/dasr_pkg.sv
// Purpose: shared constants and types for the dual-axis accelerometer serial readout
// Assumes: serial frame of 16 link clock cycles, control word shifted msb first
// Notes:   sample data is 12 bits, sent after four leading zeros

package dasr_pkg;

    // ************************************************************
    // frame geometry
    // ************************************************************
    localparam int unsigned FRAME_BITS     = 16;
    localparam int unsigned CTRL_BITS      = 8;
    localparam int unsigned SAMPLE_BITS    = 12;
    localparam int unsigned LEAD_ZEROS     = 4;
    localparam logic [4:0]  SAMPLE_EDGE    = 5'h02;
    localparam logic [4:0]  LAST_EDGE      = 5'h10;
    localparam logic [4:0]  CTRL_LAST_EDGE = 5'h08;

    // ************************************************************
    // control word fields and reset value
    // ************************************************************
    localparam int unsigned CW_IGNORED_POS = 7;
    localparam int unsigned CW_AXIS_POS    = 3;
    localparam int unsigned CW_ONE_POS     = 2;
    localparam int unsigned CW_PD_POS      = 0;
    localparam logic [7:0]  CW_RESET       = 8'h04;

    // ************************************************************
    // self-test offset, about 0.75 g at the nominal scale
    // ************************************************************
    localparam logic [11:0] SELF_TEST_OFFSET = 12'h0cd;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic        valid;
        logic        axis_select;
        logic        self_test;
    } dasr_sample_req_t;

    typedef struct packed {
        logic        axis_select;
        logic        power_down_sel;
        logic        ignored_bit;
        logic        format_ok;
    } dasr_ctrl_t;

    typedef enum logic [1:0] {
        DASR_IDLE   = 2'b00,
        DASR_ACTIVE = 2'b01,
        DASR_SLEEP  = 2'b10
    } dasr_state_t;

endpackage

// file: logic/dasr_sync.sv
// Purpose: two-flip-flop level synchroniser
// Assumes: input is a slowly changing level
// Notes:   first stage is read only by the second stage

`timescale 1ns/1ps

module dasr_sync
    import dasr_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;

endmodule

// file: logic/dasr_sample_hold.sv
// Purpose: holds the axis samples taken in the system clock domain
// Assumes: sample request arrives as a toggle from the link domain
// Notes:   the held word is stable while the link copies it after the done toggle

`timescale 1ns/1ps

module dasr_sample_hold
    import dasr_pkg::*;
(
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_nrst,
    input  wire logic                   i_req_tgl,
    input  wire logic                   i_axis_sel,
    input  wire logic                   i_self_test,
    input  wire logic [SAMPLE_BITS-1:0] i_accel_x,
    input  wire logic [SAMPLE_BITS-1:0] i_accel_y,
    output logic      [SAMPLE_BITS-1:0] o_sample,
    output logic                        o_done_tgl
);

    logic [1:0]             req_sync;
    logic                   req_seen_q;
    logic [SAMPLE_BITS-1:0] sample_q;
    logic                   done_q;
    logic                   req_evt;
    logic [SAMPLE_BITS-1:0] raw;

    dasr_sync #(.W(2)) u_sync (
        .i_clk  (i_sys_clk),
        .i_nrst (i_nrst),
        .i_d    ({i_req_tgl, i_axis_sel}),
        .o_q    (req_sync)
    );

    // ************************************************************
    // axis pick and self-test offset
    // ************************************************************
    assign req_evt = req_sync[1] ^ req_seen_q;
    assign raw     = req_sync[0] ? i_accel_y : i_accel_x;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            req_seen_q <= 1'b0;
            sample_q   <= '0;
            done_q     <= 1'b0;
        end else begin
            req_seen_q <= req_sync[1];
            if (req_evt) begin
                sample_q <= i_self_test ? raw + SELF_TEST_OFFSET : raw;
                done_q   <= ~done_q;
            end
        end
    end

    assign o_sample   = sample_q;
    assign o_done_tgl = done_q;

endmodule

// file: logic/dasr_readout.sv
// Purpose: accelerometer serial readout and control word logic
// Assumes: link clock is the serial clock from the host, still outside frames
// Notes:   sample taken at the second rising edge, shifted out on falling edges

`timescale 1ns/1ps

module dasr_readout
    import dasr_pkg::*;
(
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_nrst,
    input  wire logic                   i_sclk,
    input  wire logic                   i_accel_sel_n,
    input  wire logic                   i_temp_select_n,
    input  wire logic                   i_din,
    input  wire logic                   i_self_test_in,
    input  wire logic [SAMPLE_BITS-1:0] i_accel_x,
    input  wire logic [SAMPLE_BITS-1:0] i_accel_y,
    input  wire logic [9:0]             i_temp_data,
    output logic                        o_dout,
    output logic                        o_dout_oe_n,
    output logic [CTRL_BITS-1:0]        o_accel_control_word,
    output logic                        o_power_down,
    output logic                        o_select_clash
);

    // ************************************************************
    // link domain state
    // ************************************************************
    dasr_state_t                state_q;
    dasr_state_t                state_d;
    logic [4:0]                 edge_cnt_q;
    logic [CTRL_BITS-1:0]       shift_in_q;
    logic [CTRL_BITS-1:0]       ctrl_q;
    logic [CTRL_BITS-1:0]       ctrl_d;
    logic                       pd_q;
    logic                       pd_d;
    logic                       req_tgl_q;
    logic                       st_link;
    logic [FRAME_BITS-1:0]      out_shift_q;
    logic                       dout_q;
    logic [3:0]                 temp_cnt_q;
    logic [1:0]                 done_link;
    logic                       done_seen_q;
    logic                       done_evt;
    logic [SAMPLE_BITS-1:0]     link_sample_q;
    logic [FRAME_BITS-1:0]      frame_word;
    logic [SAMPLE_BITS-1:0]     held_sample;
    logic                       done_tgl;
    logic                       ctrl_load;
    logic                       frame_end;
    logic                       sample_now;
    logic                       accel_frame;
    logic                       temp_frame;
    logic                       link_nrst;
    logic [1:0]                 sys_sel;
    logic                       clash_q;

    assign accel_frame = ~i_accel_sel_n;
    assign temp_frame  = ~i_temp_select_n;
    // frame control resets the edge counter and both shifters while no frame is open
    assign link_nrst   = i_nrst & (accel_frame | temp_frame);

    // ************************************************************
    // edge counting, one count per rising serial clock edge
    // ************************************************************
    assign sample_now = accel_frame && (edge_cnt_q == SAMPLE_EDGE - 5'h01);
    assign ctrl_load  = accel_frame && (edge_cnt_q == CTRL_LAST_EDGE - 5'h01);
    assign frame_end  = accel_frame && (edge_cnt_q == LAST_EDGE - 5'h01);

    always_ff @(posedge i_sclk or negedge link_nrst) begin
        if (!link_nrst) begin
            edge_cnt_q <= 5'h00;
        end else if (frame_end) begin
            edge_cnt_q <= 5'h00;
        end else if (accel_frame) begin
            edge_cnt_q <= edge_cnt_q + 5'h01;
        end
    end

    // ************************************************************
    // control word capture
    // ************************************************************
    always_ff @(posedge i_sclk or negedge link_nrst) begin
        if (!link_nrst) begin
            shift_in_q <= '0;
        end else if (accel_frame && edge_cnt_q < CTRL_LAST_EDGE) begin
            shift_in_q <= {shift_in_q[CTRL_BITS-2:0], i_din};
        end
    end

    // stored word survives frame gaps, so it uses the system reset only
    always_comb begin
        ctrl_d  = ctrl_q;
        pd_d    = pd_q;
        state_d = state_q;
        if (ctrl_load) begin
            ctrl_d = {shift_in_q[CTRL_BITS-2:0], i_din};
            if (ctrl_d[CW_PD_POS]) begin
                pd_d    = 1'b1;
                state_d = DASR_SLEEP;
            end else if (!pd_q) begin
                state_d = DASR_ACTIVE;
            end
        end
        if (frame_end && state_q == DASR_SLEEP && !ctrl_q[CW_PD_POS]) begin
            pd_d    = 1'b0;
            state_d = DASR_ACTIVE;
        end
        if (!accel_frame && state_q == DASR_ACTIVE) begin
            state_d = DASR_IDLE;
        end
        if (accel_frame && state_q == DASR_IDLE) begin
            state_d = DASR_ACTIVE;
        end
    end

    always_ff @(posedge i_sclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_q  <= CW_RESET;
            pd_q    <= 1'b0;
            state_q <= DASR_IDLE;
        end else begin
            ctrl_q  <= ctrl_d;
            pd_q    <= pd_d;
            state_q <= state_d;
        end
    end

    // ************************************************************
    // sample request toward the system domain
    // ************************************************************
    always_ff @(posedge i_sclk or negedge i_nrst) begin
        if (!i_nrst) begin
            req_tgl_q <= 1'b0;
        end else if (sample_now && !pd_q) begin
            req_tgl_q <= ~req_tgl_q;
        end
    end

    // ************************************************************
    // system side: sample hold and status
    // ************************************************************
    dasr_sync #(.W(1)) u_st_sync (
        .i_clk  (i_sys_clk),
        .i_nrst (i_nrst),
        .i_d    (i_self_test_in),
        .o_q    (st_link)
    );

    dasr_sample_hold u_hold (
        .i_sys_clk   (i_sys_clk),
        .i_nrst      (i_nrst),
        .i_req_tgl   (req_tgl_q),
        .i_axis_sel  (ctrl_q[CW_AXIS_POS]),
        .i_self_test (st_link),
        .i_accel_x   (i_accel_x),
        .i_accel_y   (i_accel_y),
        .o_sample    (held_sample),
        .o_done_tgl  (done_tgl)
    );

    dasr_sync #(.W(2)) u_sel_sync (
        .i_clk  (i_sys_clk),
        .i_nrst (i_nrst),
        .i_d    ({accel_frame, temp_frame}),
        .o_q    (sys_sel)
    );

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            clash_q <= 1'b0;
        end else begin
            clash_q <= sys_sel[1] & sys_sel[0];
        end
    end

    assign o_select_clash       = clash_q;
    assign o_accel_control_word = ctrl_q;
    assign o_power_down         = pd_q;

    // ************************************************************
    // done toggle back into the link domain, settled sample copied once
    // ************************************************************
    assign done_evt   = done_link[1] ^ done_seen_q;
    assign frame_word = {{LEAD_ZEROS{1'b0}}, link_sample_q};

    // held word is stable once its toggle has crossed; survives frame gaps
    always_ff @(posedge i_sclk or negedge i_nrst) begin
        if (!i_nrst) begin
            done_link     <= 2'b00;
            done_seen_q   <= 1'b0;
            link_sample_q <= '0;
        end else begin
            done_link   <= {done_link[0], done_tgl};
            done_seen_q <= done_link[1];
            if (done_evt) begin
                link_sample_q <= held_sample;
            end
        end
    end

    // ************************************************************
    // output shifter, updated on falling edges
    // ************************************************************
    always_ff @(negedge i_sclk or negedge link_nrst) begin
        if (!link_nrst) begin
            out_shift_q <= '0;
            dout_q      <= 1'b0;
            temp_cnt_q  <= 4'h0;
        end else if (temp_frame) begin
            temp_cnt_q  <= temp_cnt_q + 4'h1;
            dout_q      <= (temp_cnt_q == 4'h0) ? 1'b0 :
                           (temp_cnt_q <= 4'ha) ? i_temp_data[4'ha - temp_cnt_q] : dout_q;
        end else if (edge_cnt_q == 5'h01) begin
            // the top, always zero, bit stood before the first falling edge
            dout_q      <= frame_word[FRAME_BITS-2];
            out_shift_q <= {frame_word[FRAME_BITS-3:0], 2'b00};
        end else begin
            dout_q      <= out_shift_q[FRAME_BITS-1];
            out_shift_q <= {out_shift_q[FRAME_BITS-2:0], 1'b0};
        end
    end

    // ************************************************************
    // output enable follows the frame selects
    // ************************************************************
    assign o_dout      = dout_q;
    assign o_dout_oe_n = ~(accel_frame | temp_frame);

endmodule

// file: dv/dasr_readout_asserts.sv
// Purpose: port checks for the accelerometer readout
// Assumes: serial clock stands still outside frames
// Notes:   edge_q is the number of the last rising edge in the frame
`timescale 1ns/1ps
module dasr_readout_asserts
    import dasr_pkg::*;
(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_nrst,
    input  wire logic                 i_sclk,
    input  wire logic                 i_accel_sel_n,
    input  wire logic                 i_temp_select_n,
    input  wire logic                 i_din,
    input  wire logic                 o_dout,
    input  wire logic                 o_dout_oe_n,
    input  wire logic [CTRL_BITS-1:0] o_accel_control_word,
    input  wire logic                 o_power_down,
    input  wire logic                 o_select_clash
);
    // ****************************************
    // frame edge counter and din history
    // ****************************************
    logic [4:0] edge_q;
    logic [7:0] hist_q;
    always_ff @(posedge i_sclk or negedge i_nrst or posedge i_accel_sel_n) begin
        if (!i_nrst || i_accel_sel_n) begin
            edge_q <= 5'h00;
        end else begin
            edge_q <= (edge_q == LAST_EDGE) ? 5'h01 : edge_q + 5'h01;
        end
    end
    always_ff @(posedge i_sclk or negedge i_nrst) begin
        if (!i_nrst) begin
            hist_q <= 8'h00;
        end else begin
            hist_q <= {hist_q[6:0], i_din};
        end
    end
    a_oe_accel_drive: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        !i_accel_sel_n |-> !o_dout_oe_n) else $error("dout idle in accel frame");
    a_release_on_deselect: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        $rose(i_accel_sel_n) && i_temp_select_n |-> o_dout_oe_n) else $error("dout not released");
    a_temp_frame_drive: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        !i_temp_select_n |-> !o_dout_oe_n) else $error("dout idle in temp frame");
    a_clash_flagged: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (!i_accel_sel_n && !i_temp_select_n) [*2] |-> ##[0:3] o_select_clash)
        else $error("select clash not flagged");
    a_word_load: assert property (@(posedge i_sclk) disable iff (!i_nrst)
        edge_q == CTRL_LAST_EDGE && !i_accel_sel_n |-> o_accel_control_word == hist_q)
        else $error("control word mismatch");
    a_pd_enter: assert property (@(posedge i_sclk) disable iff (!i_nrst)
        edge_q == CTRL_LAST_EDGE && !i_accel_sel_n && hist_q[0] |-> o_power_down)
        else $error("power-down not entered");
    a_pd_wake: assert property (@(posedge i_sclk) disable iff (!i_nrst)
        edge_q == 5'h0f && !i_accel_sel_n && o_power_down && !o_accel_control_word[0] |=> !o_power_down)
        else $error("no wake at edge 16");
    a_pd_held: assert property (@(posedge i_sclk) disable iff (!i_nrst)
        o_power_down && edge_q != 5'h0f |=> o_power_down) else $error("early wake");
    a_word_hold: assert property (@(posedge i_sclk) disable iff (!i_nrst)
        edge_q != 5'h07 |=> $stable(o_accel_control_word)) else $error("control word moved");
    a_lead_zeros: assert property (@(posedge i_sclk) disable iff (!i_nrst)
        edge_q inside {5'h01, 5'h02, 5'h03} && !i_accel_sel_n |-> !o_dout) else $error("lead bit not zero");
endmodule

bind dasr_readout dasr_readout_asserts u_chk (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_sclk(i_sclk), .i_accel_sel_n(i_accel_sel_n),
    .i_temp_select_n(i_temp_select_n), .i_din(i_din), .o_dout(o_dout), .o_dout_oe_n(o_dout_oe_n),
    .o_accel_control_word(o_accel_control_word), .o_power_down(o_power_down),
    .o_select_clash(o_select_clash)
);

// file: dv/dasr_host_model.sv
// Purpose: host serial controller driving selects, clock and data
// Assumes: serial clock period 15 ns, low and still outside frames
// Notes:   gap after each frame task call, not between its n frames, keeps the sample rate low
`timescale 1ns/1ps
module dasr_host_model #(
    parameter int unsigned GAP_NS = 100000
) (
    output logic      o_sclk,
    output logic      o_sel_n,
    output logic      o_temp_sel_n,
    output logic      o_din,
    input  wire logic i_dout
);
    // ****************************************
    // frame tasks
    // ****************************************
    initial begin
        o_sclk = 1'b0;
        o_sel_n = 1'b1;
        o_temp_sel_n = 1'b1;
        o_din = 1'b0;
    end
    task automatic pulse2();
        repeat (2) begin
            #7.5 o_sclk = 1'b1;
            #7.5 o_sclk = 1'b0;
        end
    endtask
    // n accel frames with select held low, rx holds the last frame
    task automatic frame(input logic [7:0] cw, input int n, output logic [15:0] rx);
        o_sel_n = 1'b0;
        #10;
        repeat (n) begin
            for (int k = 0; k < 16; k++) begin
                o_din = (k < 8) ? cw[7-k] : 1'b0;
                #7.5 rx = {rx[14:0], i_dout};
                o_sclk = 1'b1;
                #7.5 o_sclk = 1'b0;
            end
        end
        #10 o_sel_n = 1'b1;
        o_din = ~o_din;
        #(GAP_NS);
    endtask
    task automatic temp_frame();
        o_din = 1'b0;
        o_temp_sel_n = 1'b0;
        #10;
        pulse2();
    endtask
    task automatic overlap();
        o_temp_sel_n = 1'b0;
        o_sel_n = 1'b0;
    endtask
    task automatic release_all();
        o_sel_n = 1'b1;
        o_temp_sel_n = 1'b1;
    endtask
endmodule

// file: dv/dasr_readout_tb.sv
// Purpose: self-checking bench for the accelerometer readout
// Assumes: each frame shows the sample of the last earlier frame that began with power-down off
// Notes:   sys inputs change on the falling sys edge
`timescale 1ns/1ps
module dasr_readout_tb
    import dasr_pkg::*;
;
    // ****************************************
    // bench signals and instances
    // ****************************************
    localparam logic [7:0]  CW_X = 8'h04;
    localparam logic [7:0]  CW_Y = 8'h0c;
    localparam logic [7:0]  CW_P = 8'h05;
    localparam logic [11:0] XV   = 12'h123;
    localparam logic [11:0] YV   = 12'h456;
    logic        i_sys_clk, i_nrst, st, dout, oe_n, pd, clash;
    logic [11:0] ax;
    logic [7:0]  cw;
    logic [15:0] rx;
    wire  logic  sclk, sel_n, tsel_n, din;
    wire         dout_w;
    int          n_mismatch, n_checks;
    assign dout_w = oe_n ? 1'bz : dout;
    dasr_host_model host (.o_sclk(sclk), .o_sel_n(sel_n), .o_temp_sel_n(tsel_n), .o_din(din), .i_dout(dout_w));
    dasr_readout uut (
        .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_sclk(sclk), .i_accel_sel_n(sel_n),
        .i_temp_select_n(tsel_n), .i_din(din), .i_self_test_in(st), .i_accel_x(ax), .i_accel_y(YV),
        .i_temp_data(10'h064), .o_dout(dout), .o_dout_oe_n(oe_n), .o_accel_control_word(cw),
        .o_power_down(pd), .o_select_clash(clash)
    );
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_axis();
        host.frame(CW_X, 1, rx);
        host.frame(CW_Y, 1, rx);
        chk(rx, {4'h0, XV});
        chk({15'h0, oe_n}, 16'h0001);
        host.frame(8'h84, 1, rx);
        chk(rx, {4'h0, XV});
        chk({8'h00, cw}, 16'h0084);
        host.frame(CW_X, 1, rx);
        chk(rx, {4'h0, YV});
        $display("test axis done");
    endtask
    task automatic t_self_test();
        @(negedge i_sys_clk) st = 1'b1;
        repeat (4) @(negedge i_sys_clk);
        host.frame(CW_X, 1, rx);
        host.frame(CW_X, 1, rx);
        chk(rx, {4'h0, XV + SELF_TEST_OFFSET});
        @(negedge i_sys_clk) st = 1'b0;
        repeat (4) @(negedge i_sys_clk);
        $display("test self-test done");
    endtask
    task automatic t_continuous();
        host.frame(CW_Y, 2, rx);
        chk(rx, {4'h0, XV});
        host.frame(CW_X, 1, rx);
        chk(rx, {4'h0, YV});
        $display("test continuous done");
    endtask
    task automatic t_power_down();
        host.frame(CW_P, 1, rx);
        chk({15'h0, pd}, 16'h0001);
        @(negedge i_sys_clk) ax = 12'h7e1;
        repeat (4) @(negedge i_sys_clk);
        host.frame(CW_P, 1, rx);
        chk(rx, {4'h0, XV});
        chk({8'h00, cw}, {8'h00, CW_P});
        host.frame(CW_X, 1, rx);
        chk(rx, {4'h0, XV});
        chk({15'h0, pd}, 16'h0000);
        host.frame(CW_X, 1, rx);
        host.frame(CW_X, 1, rx);
        chk(rx, 16'h07e1);
        $display("test power-down done");
    endtask
    task automatic t_temp_clash();
        int k;
        host.temp_frame();
        chk({15'h0, oe_n}, 16'h0000);
        host.release_all();
        @(negedge i_sys_clk);
        chk({15'h0, oe_n}, 16'h0001);
        host.overlap();
        k = 0;
        while (clash !== 1'b1 && k < 8) begin
            @(negedge i_sys_clk);
            k++;
        end
        chk({15'h0, clash}, 16'h0001);
        if (k == 8) begin
            end_sim();
        end
        host.release_all();
        $display("test temp and clash done");
    endtask
    initial begin
        i_nrst = 1'b0;
        st = 1'b0;
        ax = XV;
        n_mismatch = 0;
        n_checks = 0;
        repeat (5) @(negedge i_sys_clk);
        host.pulse2();
        repeat (14) @(negedge i_sys_clk);
        i_nrst = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        t_axis();
        t_self_test();
        t_continuous();
        t_power_down();
        t_temp_clash();
        end_sim();
    end
    initial begin
        #2400000;
        $display("ERROR t=%0t timeout", $time);
        n_mismatch++;
        end_sim();
    end
endmodule
